/* File: rtl/flash_cmd_dev.sv */
`include "flash_ctl_regs.svh"

//Contract
//RL1 - Exit code in four-wire mode returns serial
//RL2 - Four-wire exit keeps latch, suspend, wrap
//RL3 - Reset aborts work, clears volatile settings
//RL4 - Reset pair accepted in both modes
//RL5 - Reset needs enable immediately before it
//RL6 - Ignore all commands during reset recovery
//RL7 - Host checks busy and suspend first; flash_cmd_host sends reset with no busy or suspend check
//RL8 - Ultra-deep sleep ignores every command
//RL9 - Entry code from deep sleep enters ultra
//RL10 - Bad length entry aborts to standby
//RL11 - Power-up starts in standby
//RL12 - Entry ignored while program/erase runs
//RL13 - Long chip-select pulse wakes ultra sleep
//RL14 - Byte during wake pulse is discarded
//RL15 - Frames during exit time are ignored
//RL16 - Power-up starts in serial mode
//RL17 - Enter four-wire needs quad enable
//RL18 - One power state; ignored frames change nothing
module flash_cmd_dev import flash_ctl_pkg::*; #(
   parameter int unsigned ENTRY_CYC = `ULTRA_ENTRY_CYC,
   parameter int unsigned EXIT_CYC  = `ULTRA_EXIT_CYC,
   parameter int unsigned WAKE_CYC  = `WAKE_PULSE_CYC,
   parameter int unsigned REC_CYC   = `RECOVERY_CYC
) (
   input  wire logic  clk,
   input  wire logic  sys_rst,
   flash_link_if.dev  link,
   input  wire logic  quad_enable_bit,
   input  wire logic  op_busy,
   input  wire logic  deep_pd_enter,
   input  wire logic  deep_pd_exit,
   input  wire logic  vol_wr,
   input  vol_t       vol_in,
   output vol_t       vol_q,
   output logic       four_wire_command_mode_q,
   output pwr_t       power_state_q,
   output logic       reset_armed_q,
   output logic       op_abort_q
);
   localparam vol_t VOL_RST = '{write_enable_latch: `WR_LATCH_RST, suspend_flag: `SUSPEND_RST,
                                read_parameter_bits: `RD_PARAM_RST, wrap_setting_bits: `WRAP_RST};

   logic [5:0]  sync_q;
   logic        cs_s;
   logic        sclk_s;
   logic [3:0]  io_s;
   logic        cs_p_q;
   logic        cs_p_d;
   logic        sclk_p_q;
   logic        sclk_p_d;
   logic [7:0]  sh_q;
   logic [7:0]  sh_d;
   logic [2:0]  bits_q;
   logic [2:0]  bits_d;
   logic        have_q;
   logic        have_d;
   logic [7:0]  first_q;
   logic [7:0]  first_d;
   logic [15:0] low_q;
   logic [15:0] low_d;
   logic [15:0] tmr_q;
   logic [15:0] tmr_d;
   logic [3:0]  oe_q;
   logic [3:0]  oe_d;
   vol_t        vol_d;
   logic        fw_d;
   pwr_t        pwr_d;
   logic        armed_d;
   logic        abort_d;
   logic        sclk_rise;
   logic        cs_fall;
   logic        cs_rise;
   logic [7:0]  nxt_sh;
   logic [2:0]  nxt_bits;
   logic        whole;

   // ************************************************
   // Pin synchronisers and edge detection
   // ************************************************
   sync2 #(.W(6)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({link.cs_n, link.sclk, link.io}),
      .q       (sync_q)
   );

   assign cs_s      = sync_q[5];
   assign sclk_s    = sync_q[4];
   assign io_s      = sync_q[3:0];
   assign sclk_rise = sclk_s & ~sclk_p_q & ~cs_s;
   assign cs_fall   = ~cs_s & cs_p_q;
   assign cs_rise   = cs_s & ~cs_p_q;
   assign whole     = have_q & (bits_q == 3'h0);

   assign link.d_io_o  = 4'h0;
   assign link.d_io_oe = oe_q;

   // ************************************************
   // Frame shifter
   // ************************************************
   always_comb begin
      cs_p_d   = cs_s;
      sclk_p_d = sclk_s;
      sh_d     = sh_q;
      bits_d   = bits_q;
      have_d   = have_q;
      first_d  = first_q;
      low_d    = low_q;
      nxt_sh   = sh_q;
      nxt_bits = bits_q;
      if (four_wire_command_mode_q) begin
         nxt_sh   = {sh_q[3:0], io_s};
         nxt_bits = 3'(bits_q + 3'h4);
      end else begin
         nxt_sh   = {sh_q[6:0], io_s[0]};
         nxt_bits = 3'(bits_q + 3'h1);
      end
      if (cs_fall) begin
         sh_d   = 8'h00;
         bits_d = 3'h0;
         have_d = 1'b0;
         low_d  = 16'h0000;
      end else if (!cs_s) begin
         if (low_q != 16'hFFFF) begin
            low_d = 16'(low_q + 16'h0001);
         end
         if (sclk_rise) begin
            sh_d   = nxt_sh;
            bits_d = nxt_bits;
            if (nxt_bits == 3'h0 && !have_q) begin
               have_d  = 1'b1;
               first_d = nxt_sh;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_p_q   <= 1'b1;
         sclk_p_q <= 1'b0;
         sh_q     <= 8'h00;
         bits_q   <= 3'h0;
         have_q   <= 1'b0;
         first_q  <= 8'h00;
         low_q    <= 16'h0000;
      end else begin
         cs_p_q   <= cs_p_d;
         sclk_p_q <= sclk_p_d;
         sh_q     <= sh_d;
         bits_q   <= bits_d;
         have_q   <= have_d;
         first_q  <= first_d;
         low_q    <= low_d;
      end
   end

   // ************************************************
   // Command decode and power state
   // ************************************************
   always_comb begin
      vol_d   = vol_q;
      fw_d    = four_wire_command_mode_q;
      pwr_d   = power_state_q;
      armed_d = reset_armed_q;
      abort_d = 1'b0;
      tmr_d   = tmr_q;
      oe_d    = 4'h0;                                                   // RL18
      if (tmr_q != 16'h0000) begin
         tmr_d = 16'(tmr_q - 16'h0001);
      end
      unique case (power_state_q)
         PS_STANDBY: begin
            if (vol_wr) begin
               vol_d = vol_in;
            end
            if (deep_pd_enter && cs_s) begin
               pwr_d = PS_DEEP;
            end
            if (cs_rise && have_q) begin
               armed_d = (first_q == `CMD_RESET_ENABLE);                 // RL5
               if (first_q == `CMD_RESET && reset_armed_q) begin         // RL4
                  vol_d   = VOL_RST;                                     // RL3
                  fw_d    = `FOUR_WIRE_RST;                              // RL3
                  abort_d = 1'b1;                                        // RL3
                  pwr_d   = PS_RECOVER;                                  // RL6
                  tmr_d   = 16'(REC_CYC - 1);                            // RL6
               end else if (first_q == `CMD_EXIT_FOUR_WIRE && four_wire_command_mode_q) begin
                  fw_d = 1'b0;                                           // RL1 RL2
               end else if (first_q == `CMD_ENTER_FOUR_WIRE && !four_wire_command_mode_q
                            && quad_enable_bit) begin                    // RL17
                  fw_d                    = 1'b1;
                  vol_d.wrap_setting_bits = `WRAP_RST;
               end
            end
         end
         PS_DEEP: begin
            if (deep_pd_exit && cs_s) begin
               pwr_d = PS_STANDBY;
            end
            if (cs_rise && (have_q || bits_q != 3'h0)) begin
               if (whole && first_q == `CMD_ULTRA_SLEEP) begin           // RL9
                  if (!op_busy) begin                                    // RL12
                     pwr_d = PS_ULTRA_IN;
                     tmr_d = 16'(ENTRY_CYC - 1);
                  end
               end else if (!have_q || first_q == `CMD_ULTRA_SLEEP) begin
                  pwr_d = PS_STANDBY;                                    // RL10
               end
            end
         end
         PS_ULTRA_IN: begin
            if (tmr_q == 16'h0000) begin
               pwr_d = PS_ULTRA;                                         // RL9
            end
         end
         PS_ULTRA: begin                                                 // RL8
            if (cs_rise && low_q >= 16'(WAKE_CYC)) begin                 // RL13 RL14
               pwr_d = PS_ULTRA_OUT;
               tmr_d = 16'(EXIT_CYC - 1);
            end
         end
         PS_ULTRA_OUT: begin
            if (tmr_q == 16'h0000) begin                                 // RL15
               pwr_d = PS_STANDBY;                                       // RL13
            end
         end
         PS_RECOVER: begin
            if (tmr_q == 16'h0000) begin                                 // RL6
               pwr_d = PS_STANDBY;
            end
         end
         default: begin
            pwr_d = PS_STANDBY;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         vol_q                    <= VOL_RST;
         four_wire_command_mode_q <= `FOUR_WIRE_RST;                     // RL16
         power_state_q            <= PS_STANDBY;                         // RL11
         reset_armed_q            <= 1'b0;
         op_abort_q               <= 1'b0;
         tmr_q                    <= 16'h0000;
         oe_q                     <= 4'h0;
      end else begin
         vol_q                    <= vol_d;
         four_wire_command_mode_q <= fw_d;
         power_state_q            <= pwr_d;
         reset_armed_q            <= armed_d;
         op_abort_q               <= abort_d;
         tmr_q                    <= tmr_d;
         oe_q                     <= oe_d;
      end
   end
endmodule

/* File: rtl/flash_cmd_host.sv */
`include "flash_ctl_regs.svh"

module flash_cmd_host import flash_ctl_pkg::*; #(
   parameter int unsigned HALF_DIV = `HOST_HALF_DIV,
   parameter int unsigned WAKE_CYC = `WAKE_PULSE_CYC,
   parameter int unsigned EXIT_CYC = `ULTRA_EXIT_CYC,
   parameter int unsigned REC_CYC  = `RECOVERY_CYC
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   flash_link_if.host      link,
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_byte,
   input  wire logic [5:0] cmd_bits,
   input  wire logic       cmd_quad,
   input  wire logic       wake_valid,
   output logic            ready_q
);
   hst_t        st_q;
   hst_t        st_d;
   logic        ready_d;
   logic        cs_n_q;
   logic        cs_n_d;
   logic        sclk_q;
   logic        sclk_d;
   logic [3:0]  dout_q;
   logic [3:0]  dout_d;
   logic [3:0]  oe_q;
   logic [3:0]  oe_d;
   logic [7:0]  sh_q;
   logic [7:0]  sh_d;
   logic [5:0]  left_q;
   logic [5:0]  left_d;
   logic        quad_q;
   logic        quad_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        rst_q;
   logic        rst_d;
   logic [5:0]  step;

   assign link.cs_n    = cs_n_q;
   assign link.sclk    = sclk_q;
   assign link.h_io_o  = dout_q;
   assign link.h_io_oe = oe_q;
   assign step         = quad_q ? 6'h4 : 6'h1;

   // ************************************************
   // Frame sequencer
   // ************************************************
   always_comb begin
      st_d    = st_q;
      ready_d = ready_q;
      cs_n_d  = cs_n_q;
      sclk_d  = sclk_q;
      dout_d  = dout_q;
      oe_d    = oe_q;
      sh_d    = sh_q;
      left_d  = left_q;
      quad_d  = quad_q;
      rst_d   = rst_q;
      cnt_d   = (cnt_q != 16'h0000) ? 16'(cnt_q - 16'h0001) : cnt_q;
      unique case (st_q)
         HS_IDLE: begin
            if (cmd_valid) begin
               st_d    = HS_SHIFT;
               ready_d = 1'b0;
               cs_n_d  = 1'b0;
               quad_d  = cmd_quad;
               oe_d    = cmd_quad ? 4'hF : 4'h1;
               dout_d  = cmd_quad ? cmd_byte[7:4] : {3'h0, cmd_byte[7]};
               sh_d    = cmd_quad ? {cmd_byte[3:0], 4'h0} : {cmd_byte[6:0], 1'b0};
               left_d  = cmd_bits;
               rst_d   = (cmd_byte == `CMD_RESET) && (cmd_bits >= 6'h08);
               cnt_d   = 16'(HALF_DIV - 1);
            end else if (wake_valid) begin
               st_d    = HS_WAKE;                                        // RL13
               ready_d = 1'b0;
               cs_n_d  = 1'b0;
               cnt_d   = 16'(WAKE_CYC + 4);
            end
         end
         HS_SHIFT: begin
            if (cnt_q == 16'h0000) begin
               cnt_d = 16'(HALF_DIV - 1);
               if (!sclk_q) begin
                  sclk_d = 1'b1;
                  left_d = (left_q > step) ? 6'(left_q - step) : 6'h00;
               end else begin
                  sclk_d = 1'b0;
                  if (left_q == 6'h00) begin
                     st_d   = HS_GAP;                                    // RL10
                     cs_n_d = 1'b1;
                     oe_d   = 4'h0;
                     cnt_d  = rst_q ? 16'(REC_CYC + 8) : 16'(2 * HALF_DIV);
                  end else begin
                     dout_d = quad_q ? sh_q[7:4] : {3'h0, sh_q[7]};
                     sh_d   = quad_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
                  end
               end
            end
         end
         HS_GAP: begin
            if (cnt_q == 16'h0000) begin
               st_d    = HS_IDLE;
               ready_d = 1'b1;
            end
         end
         HS_WAKE: begin
            if (cnt_q == 16'h0000) begin
               st_d   = HS_EXIT;
               cs_n_d = 1'b1;
               cnt_d  = 16'(EXIT_CYC + 8);
            end
         end
         HS_EXIT: begin
            if (cnt_q == 16'h0000) begin                                 // RL15
               st_d    = HS_IDLE;
               ready_d = 1'b1;
            end
         end
         default: begin
            st_d = HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q    <= HS_IDLE;
         ready_q <= 1'b1;
         cs_n_q  <= 1'b1;
         sclk_q  <= 1'b0;
         dout_q  <= 4'h0;
         oe_q    <= 4'h0;
         sh_q    <= 8'h00;
         left_q  <= 6'h00;
         quad_q  <= 1'b0;
         cnt_q   <= 16'h0000;
         rst_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         ready_q <= ready_d;
         cs_n_q  <= cs_n_d;
         sclk_q  <= sclk_d;
         dout_q  <= dout_d;
         oe_q    <= oe_d;
         sh_q    <= sh_d;
         left_q  <= left_d;
         quad_q  <= quad_d;
         cnt_q   <= cnt_d;
         rst_q   <= rst_d;
      end
   end
endmodule

/* File: rtl/flash_ctl_pkg.sv */
package flash_ctl_pkg;

   // ************************************************
   // Device power state
   // ************************************************
   typedef enum logic [2:0] {
      PS_STANDBY   = 3'b000,
      PS_DEEP      = 3'b001,
      PS_ULTRA_IN  = 3'b010,
      PS_ULTRA     = 3'b011,
      PS_ULTRA_OUT = 3'b100,
      PS_RECOVER   = 3'b101
   } pwr_t;

   // ************************************************
   // Host sequencer state
   // ************************************************
   typedef enum logic [2:0] {
      HS_IDLE  = 3'b000,
      HS_SHIFT = 3'b001,
      HS_GAP   = 3'b010,
      HS_WAKE  = 3'b011,
      HS_EXIT  = 3'b100
   } hst_t;

   // ************************************************
   // Volatile settings
   // ************************************************
   typedef struct packed {
      logic       write_enable_latch;
      logic       suspend_flag;
      logic [7:0] read_parameter_bits;
      logic [2:0] wrap_setting_bits;
   } vol_t;

endpackage

/* File: rtl/flash_ctl_regs.svh */
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

// ************************************************
// Command codes
// ************************************************
`define CMD_EXIT_FOUR_WIRE  8'hFF
`define CMD_ENTER_FOUR_WIRE 8'h38
`define CMD_RESET_ENABLE    8'h66
`define CMD_RESET           8'h99
`define CMD_ULTRA_SLEEP     8'h79

// ************************************************
// Reset values
// ************************************************
`define FOUR_WIRE_RST       1'b0
`define WR_LATCH_RST        1'b0
`define SUSPEND_RST         1'b0
`define RD_PARAM_RST        8'h00
`define WRAP_RST            3'h0

// ************************************************
// Timing
// ************************************************
`define CLK_MHZ             100
`define RECOVERY_NS         28000
`define RECOVERY_CYC        ((`RECOVERY_NS * `CLK_MHZ + 999) / 1000)
`define ULTRA_ENTRY_CYC     10
`define ULTRA_EXIT_CYC      50
`define WAKE_PULSE_CYC      20
`define HOST_HALF_DIV       4

`endif

/* File: rtl/flash_link_if.sv */
interface flash_link_if;
   logic       cs_n;
   logic       sclk;
   logic [3:0] h_io_o;
   logic [3:0] h_io_oe;
   logic [3:0] d_io_o;
   logic [3:0] d_io_oe;
   logic [3:0] io;

   // Wire level from the enables, pulled up when nobody drives
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io[i] = h_io_oe[i] ? h_io_o[i] : (d_io_oe[i] ? d_io_o[i] : 1'b1);
      end
   end

   modport host (output cs_n, sclk, h_io_o, h_io_oe, input d_io_o, d_io_oe, io);
   modport dev  (input cs_n, sclk, h_io_o, h_io_oe, io, output d_io_o, d_io_oe);
endinterface

/* File: rtl/sync2.sv */
module sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   // ************************************************
   // Two-stage synchroniser
   // ************************************************
   always_comb begin
      meta_d = d;
      q_d    = meta_q;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '1;
         q      <= '1;
      end else begin
         meta_q <= meta_d;
         q      <= q_d;
      end
   end
endmodule

/* File: test/flash_link_monitor.sv */
module flash_link_monitor (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic [3:0] h_io_o,
   input wire logic [3:0] h_io_oe,
   input wire logic [3:0] d_io_o,
   input wire logic [3:0] d_io_oe,
   input wire logic [3:0] io
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ************************************************
   // Serial clock shape
   // ************************************************
   sequence clk_high_s;
      sclk [*4] ##1 !sclk;
   endsequence

   sequence clk_low_s;
      !sclk [*4];
   endsequence

   // ************************************************
   // Link checks
   // ************************************************
   dev_undriven_a: assert property (d_io_oe == 4'h0)
      else $error("Device drove the link");
   idle_level_a: assert property ((h_io_oe == 4'h0) && (d_io_oe == 4'h0) |-> io == 4'hF)
      else $error("Undriven link not pulled up");
   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("Clock moved while deselected");
   oe_framed_a: assert property (cs_n |-> h_io_oe == 4'h0)
      else $error("Host drove data while deselected");
   high_len_a: assert property ($rose(sclk) |-> clk_high_s)
      else $error("Clock high phase wrong");
   low_len_a: assert property ($fell(sclk) |-> clk_low_s)
      else $error("Clock low phase too short");
   select_lead_a: assert property ($fell(cs_n) |-> clk_low_s)
      else $error("Clock rose too soon after select");
   data_hold_a: assert property ($rose(sclk) |-> $stable(h_io_o) [*4])
      else $error("Data moved while clock high");
   gap_len_a: assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("Deselect gap too short");
endmodule

/* File: test/test_flash_mode_reset_power_control.sv */
module test_flash_mode_reset_power_control import flash_ctl_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      pwr_t       p;
      logic       fw;
      logic       ar;
      vol_t       v;
      logic [3:0] ab;
   } note_t;

   logic       clk;
   logic       sys_rst;
   logic       quad_enable_bit;
   logic       op_busy;
   logic       deep_pd_enter;
   logic       deep_pd_exit;
   logic       vol_wr;
   vol_t       vol_in;
   vol_t       vol_q;
   logic       four_wire_command_mode_q;
   pwr_t       power_state_q;
   logic       reset_armed_q;
   logic       op_abort_q;
   logic       cmd_valid;
   logic [7:0] cmd_byte;
   logic [5:0] cmd_bits;
   logic       cmd_quad;
   logic       wake_valid;
   logic       ready_q;
   logic       rdy_prev;
   logic [3:0] ab_cnt;
   logic [3:0] exp_ab;
   logic [7:0] rb;
   vol_t       rv;
   vol_t       w;
   note_t      nt;
   note_t      notes[$];
   int         mismatches;
   int         check_count;
   int         seed;

   // ************************************************
   // Design
   // ************************************************
   flash_link_if u_flash_link_if ();

   flash_cmd_host #(.REC_CYC(4)) u_flash_cmd_host (
      .clk(clk), .sys_rst(sys_rst), .link(u_flash_link_if), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .cmd_bits(cmd_bits), .cmd_quad(cmd_quad),
      .wake_valid(wake_valid), .ready_q(ready_q));

   flash_cmd_dev #(.ENTRY_CYC(1), .REC_CYC(200)) u_flash_cmd_dev (
      .clk(clk), .sys_rst(sys_rst), .link(u_flash_link_if), .quad_enable_bit(quad_enable_bit),
      .op_busy(op_busy), .deep_pd_enter(deep_pd_enter), .deep_pd_exit(deep_pd_exit),
      .vol_wr(vol_wr), .vol_in(vol_in), .vol_q(vol_q),
      .four_wire_command_mode_q(four_wire_command_mode_q), .power_state_q(power_state_q),
      .reset_armed_q(reset_armed_q), .op_abort_q(op_abort_q));

   flash_link_monitor u_flash_link_monitor (
      .clk(clk), .sys_rst(sys_rst), .cs_n(u_flash_link_if.cs_n), .sclk(u_flash_link_if.sclk),
      .h_io_o(u_flash_link_if.h_io_o), .h_io_oe(u_flash_link_if.h_io_oe),
      .d_io_o(u_flash_link_if.d_io_o), .d_io_oe(u_flash_link_if.d_io_oe),
      .io(u_flash_link_if.io));

   // ************************************************
   // Tasks
   // ************************************************
   task automatic end_of_test();
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cmp_pwr(input pwr_t got, input pwr_t exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_vol(input vol_t got, input vol_t exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic [5:0] n, input logic q,
                       input logic wk, input pwr_t p, input logic fw, input logic ar,
                       input vol_t v);
      int k;
      k = 0;
      @(posedge clk);
      while (ready_q !== 1'b1 && k < 5000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 5000) begin
         mismatches++;
         end_of_test();
      end
      notes.push_back({p, fw, ar, v, exp_ab});
      cmd_valid <= !wk;
      wake_valid <= wk;
      cmd_byte <= b;
      cmd_bits <= n;
      cmd_quad <= q;
      @(posedge clk);
      cmd_valid <= 1'b0;
      wake_valid <= 1'b0;
   endtask

   task automatic pulse_deep(input logic ex);
      @(posedge clk);
      while (ready_q !== 1'b1) begin
         @(posedge clk);
      end
      deep_pd_enter <= !ex;
      deep_pd_exit <= ex;
      @(posedge clk);
      deep_pd_enter <= 1'b0;
      deep_pd_exit <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // ************************************************
   // Result watcher
   // ************************************************
   always @(negedge clk) begin
      if (op_abort_q === 1'b1) begin
         ab_cnt <= ab_cnt + 4'h1;
      end
      if (ready_q === 1'b1 && rdy_prev === 1'b0 && notes.size() > 0) begin
         nt = notes.pop_front();
         cmp_pwr(power_state_q, nt.p);
         cmp_bit(four_wire_command_mode_q, nt.fw);
         cmp_bit(reset_armed_q, nt.ar);
         cmp_vol(vol_q, nt.v);
         cmp_bit(ab_cnt == nt.ab, 1'b1);
      end
      rdy_prev <= ready_q;
   end

   // ************************************************
   // Clock, watchdog, stimulus
   // ************************************************
   always #5 clk = ~clk;

   initial begin
      #200us;
      mismatches++;
      end_of_test();
   end

   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      {quad_enable_bit, op_busy, deep_pd_enter, deep_pd_exit, vol_wr} = 5'h00;
      {cmd_valid, cmd_quad, wake_valid} = 3'h0;
      cmd_byte = 8'h00;
      cmd_bits = 6'h00;
      vol_in = '0;
      rdy_prev = 1'b1;
      ab_cnt = 4'h0;
      exp_ab = 4'h0;
      mismatches = 0;
      check_count = 0;
      seed = 88055;
      rv = 13'($random(seed));
      rb = 8'($random(seed));
      if (rb inside {8'h66, 8'h99, 8'h38, 8'hFF, 8'h79}) begin
         rb = 8'h05;
      end
      w = rv;
      w.wrap_setting_bits = 3'h0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      send(8'h00, 6'h04, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b0, rv);
      @(posedge clk);
      vol_in <= rv;
      vol_wr <= 1'b1;
      @(posedge clk);
      vol_wr <= 1'b0;
      send(rb, 6'h08, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b0, rv);
      send(8'h38, 6'h08, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b0, rv);
      send(8'h66, 6'h08, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b1, rv);
      send(rb, 6'h08, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b0, rv);
      send(8'h99, 6'h08, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b0, rv);
      quad_enable_bit <= 1'b1;
      send(8'h38, 6'h08, 1'b0, 1'b0, PS_STANDBY, 1'b1, 1'b0, w);
      send(8'hFF, 6'h08, 1'b1, 1'b0, PS_STANDBY, 1'b0, 1'b0, w);
      send(8'h38, 6'h08, 1'b0, 1'b0, PS_STANDBY, 1'b1, 1'b0, w);
      send(8'h66, 6'h08, 1'b1, 1'b0, PS_STANDBY, 1'b1, 1'b1, w);
      exp_ab = exp_ab + 4'h1;
      send(8'h99, 6'h08, 1'b1, 1'b0, PS_RECOVER, 1'b0, 1'b0, '0);
      send(8'h66, 6'h08, 1'b0, 1'b0, PS_RECOVER, 1'b0, 1'b0, '0);
      repeat (200) @(posedge clk);
      send(8'h00, 6'h04, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b0, '0);
      pulse_deep(1'b0);
      send(rb, 6'h08, 1'b0, 1'b0, PS_DEEP, 1'b0, 1'b0, '0);
      op_busy <= 1'b1;
      send(8'h79, 6'h10, 1'b0, 1'b0, PS_DEEP, 1'b0, 1'b0, '0);
      send(8'h79, 6'h0C, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b0, '0);
      op_busy <= 1'b0;
      pulse_deep(1'b0);
      send(8'h79, 6'h04, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b0, '0);
      pulse_deep(1'b0);
      send(8'h79, 6'h10, 1'b0, 1'b0, PS_ULTRA, 1'b0, 1'b0, '0);
      send(8'h66, 6'h08, 1'b0, 1'b0, PS_ULTRA_OUT, 1'b0, 1'b0, '0);
      repeat (140) @(posedge clk);
      pulse_deep(1'b0);
      send(8'h79, 6'h10, 1'b0, 1'b0, PS_ULTRA, 1'b0, 1'b0, '0);
      send(8'h00, 6'h00, 1'b0, 1'b1, PS_STANDBY, 1'b0, 1'b0, '0);
      pulse_deep(1'b0);
      pulse_deep(1'b1);
      send(8'h66, 6'h08, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b1, '0);
      send(8'h00, 6'h04, 1'b0, 1'b0, PS_STANDBY, 1'b0, 1'b1, '0);
      repeat (100) @(posedge clk);
      cmp_bit(notes.size() == 0, 1'b1);
      end_of_test();
   end
endmodule
